// [adc_sw_trigger.v]
// Software trigger program registers, conversion sequencer and APB slave
//
// Contract
// [R1] Software starts a conversion sequence directly, and the program slots decide what is converted.
// [R2] Twelve 8-bit slots numbered 0 to 11 are packed four to each 32-bit program register.
// [R3] A slot takes part in a software conversion only while its enable bit is 1.
// [R4] Each slot holds a 5-bit channel select choosing the analog input sampled.
// [R5] Codes 9, 10, 11, 12 and 16 pick inputs nine, ten, eleven, twelve and sixteen; others are reserved.
// [R6] The result of slot n lands in conversion result register n.
// [R7] Completion of the software sequence raises the software conversion done interrupt.
// [R8] Slot 4k+j sits in byte j with enable at the top bit, channel in the low five, middle bits zero, reset zero.
// [R9] Enabled slots are converted in ascending order and disabled slots leave their results alone.
`include "adc_sw_map.vh"
`default_nettype none

module adc_sw_trigger
(
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst_b,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Analog converter
  output reg  [4:0]  conv_channel,
  output reg         conv_start,
  input  wire        conv_done,
  input  wire [11:0] conv_data,
  // Interrupt
  output reg         software_conversion_done_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State encoding
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_SCAN = 4'b0010;
  localparam [3:0] ST_CONV = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;
  // Converter answer limit; a silent converter cannot stall the sequence
  localparam [31:0] CONV_LIMIT = `CONV_CYCLES * 4;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg  [95:0] prog;
  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg  [3:0]  cur_idx;
  reg  [3:0]  scan_from;
  reg  [1:0]  irq_status;
  reg  [1:0]  irq_mask;
  reg         done_sync1;
  reg         done_sync2;
  reg         done_prev;
  reg  [11:0] data_sync1;
  reg  [11:0] data_sync2;
  reg  [15:0] tmo_cnt;
  reg         res_wr;
  wire        found;
  wire [3:0]  slot_idx;
  wire [4:0]  slot_channel;
  wire        slot_reserved;
  wire [11:0] res_rd;
  wire        acc;
  wire        wr_acc;
  wire        rd_acc;
  wire        start_req;
  wire        done_edge;
  wire        seq_end;
  wire        skip_event;
  wire        conv_end;
  wire [1:0]  irq_clear;
  wire [1:0]  irq_event;
  reg  [31:0] rd_mux;
  reg         addr_bad;

  // Mask writable bits of one register: keep enable and channel only
  function [31:0] prog_mask;
    input [31:0] v;
    begin
      prog_mask = v & {4{`SLOT_WRITE_MASK}}; // [R8]
    end
  endfunction

  // Result register index from a byte address; the result block sits on a
  // 64-byte boundary, so address bits 5:2 are the slot number
  function [3:0] res_index;
    input [11:0] a;
    begin
      res_index = a[5:2]; // [R6]
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign acc       = psel && penable && pready;
  assign wr_acc    = acc && pwrite && !addr_bad;
  assign rd_acc    = acc && !pwrite && !addr_bad;
  // A start is only honoured while idle; the sequencer ignores it otherwise
  assign start_req = wr_acc && (paddr == `START_OFS) && pwdata[0]; // [R1]

  // Read data mux and address check
  always @*
  begin
    rd_mux   = 32'h00000000;
    addr_bad = 1'b0;
    case (paddr)
      `SLOTS_0_3_OFS:  rd_mux = prog[31:0];
      `SLOTS_4_7_OFS:  rd_mux = prog[63:32];
      `SLOTS_8_11_OFS: rd_mux = prog[95:64];
      `START_OFS:      rd_mux = 32'h00000000;
      `STATUS_OFS:     rd_mux = {27'h0000000, (state != ST_IDLE), cur_idx};
      `IRQ_STATUS_OFS: rd_mux = {30'h00000000, irq_status};
      `IRQ_MASK_OFS:   rd_mux = {30'h00000000, irq_mask};
      default:
      begin
        if (paddr >= `RESULT_BASE_OFS && paddr <= `RESULT_LAST_OFS && paddr[1:0] == 2'b00)
          rd_mux = {20'h00000, res_rd};
        else
          addr_bad = 1'b1;
      end
    endcase
  end

  // APB answer: one wait state, error on unmapped address
  // Read data is zero outside reads, so a stale word never reaches the bus
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel && !pready && penable;
      pslverr <= psel && !pready && penable && addr_bad;
      prdata  <= (psel && !pwrite && !addr_bad) ? rd_mux : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program registers, four slots per word
  // Reserved middle bits are dropped on write and read back as zero
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      prog <= {3{`PROG_RESET}}; // [R8]
    else if (wr_acc)
    begin
      if (paddr == `SLOTS_0_3_OFS)
        prog[31:0]  <= prog_mask(pwdata); // [R2]
      if (paddr == `SLOTS_4_7_OFS)
        prog[63:32] <= prog_mask(pwdata); // [R2]
      if (paddr == `SLOTS_8_11_OFS)
        prog[95:64] <= prog_mask(pwdata); // [R2]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter done and data pass two flip-flops
  // Data is taken two cycles after done rises, when it has long settled
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      done_sync1 <= 1'b0;
      done_sync2 <= 1'b0;
      done_prev  <= 1'b0;
      data_sync1 <= 12'h000;
      data_sync2 <= 12'h000;
    end
    else
    begin
      done_sync1 <= conv_done;
      done_sync2 <= done_sync1;
      done_prev  <= done_sync2;
      data_sync1 <= conv_data;
      data_sync2 <= data_sync1;
    end
  end

  assign done_edge = done_sync2 && !done_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Next enabled slot search
  slot_decode u_slot_decode
  (
    .prog          (prog),
    .from_idx      (scan_from),
    .found         (found),
    .slot_idx      (slot_idx),
    .slot_channel  (slot_channel),
    .slot_reserved (slot_reserved)
  );

  // Sequencer next state: scan for a slot, convert it, scan again from the
  // slot after it, and end once no enabled slot is left
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (start_req) // [R1]
          next_state = ST_SCAN;
      end
      ST_SCAN:
      begin
        // A reserved code stays here one cycle while the scan steps past it
        if (found && !slot_reserved)
          next_state = ST_CONV;
        else if (!found)
          next_state = ST_DONE;
      end
      ST_CONV:
      begin
        if (conv_end)
        begin
          if (cur_idx == 4'd11)
            next_state = ST_DONE;
          else
            next_state = ST_SCAN;
        end
      end
      ST_DONE:
      begin
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Conversion ends on a done edge or when the answer limit runs out
  assign conv_end   = done_edge || (tmo_cnt == 16'h0000);
  assign seq_end    = (state == ST_DONE);
  assign skip_event = (state == ST_SCAN) && found && slot_reserved;

  // Sequencer registers: walk slots upward, skip disabled ones
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state        <= ST_IDLE;
      cur_idx      <= 4'h0;
      scan_from    <= 4'h0;
      conv_channel <= 5'h00;
      conv_start   <= 1'b0;
      res_wr       <= 1'b0;
      tmo_cnt      <= 16'h0000;
    end
    else
    begin
      state      <= next_state;
      conv_start <= 1'b0;
      res_wr     <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          scan_from <= 4'h0;
        end
        ST_SCAN:
        begin
          if (found && !slot_reserved)
          begin
            cur_idx      <= slot_idx; // [R9]
            conv_channel <= slot_channel; // [R4] [R5]
            conv_start   <= 1'b1;
            tmo_cnt      <= CONV_LIMIT[15:0];
          end
          else if (found)
            scan_from <= slot_idx + 4'd1; // reserved code: skip slot
        end
        ST_CONV:
        begin
          tmo_cnt <= tmo_cnt - 16'h0001;
          if (done_edge)
            res_wr <= 1'b1; // [R6]
          if (conv_end)
            scan_from <= cur_idx + 4'd1; // [R9]
        end
        default:
        begin
          scan_from <= 4'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result registers indexed by slot number
  result_store u_result_store
  (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .wr_en   (res_wr),
    .wr_idx  (cur_idx),
    .wr_data (data_sync2),
    .rd_idx  (res_index(paddr)),
    .rd_data (res_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Only bits returned by the read are cleared, so an event that lands
  // between data capture and the access edge is kept
  assign irq_clear = (rd_acc && paddr == `IRQ_STATUS_OFS) ? prdata[1:0] : 2'b00;
  assign irq_event = {skip_event, seq_end};

  // Sticky interrupt status; set wins over read clear
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_status                   <= 2'b00;
      irq_mask                     <= 2'b00;
      software_conversion_done_irq <= 1'b0;
    end
    else
    begin
      irq_status <= (irq_status & ~irq_clear) | irq_event; // [R7]
      if (wr_acc && paddr == `IRQ_MASK_OFS)
        irq_mask <= pwdata[1:0];
      software_conversion_done_irq <= |(irq_status & irq_mask); // [R7]
    end
  end

endmodule // adc_sw_trigger

`default_nettype wire

// [adc_sw_map.vh]
// Register map, field layout and timing constants of the software-started conversion unit
`ifndef ADC_SW_MAP_VH
`define ADC_SW_MAP_VH

// Register byte offsets
`define SLOTS_0_3_OFS     12'h000
`define SLOTS_4_7_OFS     12'h004
`define SLOTS_8_11_OFS    12'h008
`define START_OFS         12'h00c
`define STATUS_OFS        12'h010
`define IRQ_STATUS_OFS    12'h014
`define IRQ_MASK_OFS      12'h018
`define RESULT_BASE_OFS   12'h040
`define RESULT_LAST_OFS   12'h06c

// Slot field layout inside each byte
`define SLOT_EN_BIT       7
`define SLOT_CH_MSB       4
`define SLOT_WRITE_MASK   8'h9f
`define SLOT_COUNT        12
`define PROG_RESET        32'h00000000

// Channel select codes
`define CH_NINE           5'h09
`define CH_TEN            5'h0a
`define CH_ELEVEN         5'h0b
`define CH_TWELVE         5'h0c
`define CH_SIXTEEN        5'h10

// Interrupt status bits
`define IRQ_DONE_BIT      0
`define IRQ_RESERVED_BIT  1

// Conversion time and clock period behind the converter answer limit
`define CONV_TIME_NS      1000
`define CLK_PERIOD_NS     20
`define CONV_CYCLES       (`CONV_TIME_NS / `CLK_PERIOD_NS)

`endif

// [slot_decode.v]
// Picks the next enabled slot at or after a start index and checks its channel code
`include "adc_sw_map.vh"
`default_nettype none

module slot_decode
(
  // Slot programming
  input  wire [95:0] prog,
  input  wire [3:0]  from_idx,
  // Result of the search
  output reg         found,
  output reg  [3:0]  slot_idx,
  output reg  [4:0]  slot_channel,
  output reg         slot_reserved
);

  // Lowest enabled slot not below from_idx
  integer i;
  always @*
  begin
    found         = 1'b0;
    slot_idx      = 4'h0;
    slot_channel  = 5'h00;
    slot_reserved = 1'b0;
    for (i = `SLOT_COUNT - 1; i >= 0; i = i - 1)
    begin
      if (prog[i*8 + `SLOT_EN_BIT] && (i[3:0] >= from_idx)) // [R3] [R9]
      begin
        found        = 1'b1;
        slot_idx     = i[3:0];
        slot_channel = prog[i*8 +: 5]; // [R4]
      end
    end
    // Reserved codes are flagged, never mapped to a pin
    case (slot_channel) // [R5]
      `CH_NINE, `CH_TEN, `CH_ELEVEN, `CH_TWELVE, `CH_SIXTEEN: slot_reserved = 1'b0;
      default: slot_reserved = found;
    endcase
  end

endmodule // slot_decode

`default_nettype wire

// [result_store.v]
// Twelve conversion result registers, one per program slot
`include "adc_sw_map.vh"
`default_nettype none

module result_store
(
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst_b,
  // Write port from the sequencer
  input  wire        wr_en,
  input  wire [3:0]  wr_idx,
  input  wire [11:0] wr_data,
  // Read port to the bus
  input  wire [3:0]  rd_idx,
  output wire [11:0] rd_data
);

  reg [11:0] result_mem [0:11];
  integer k;

  // Only the addressed slot's result changes
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (k = 0; k < `SLOT_COUNT; k = k + 1)
        result_mem[k] <= 12'h000;
    end
    else if (wr_en && (wr_idx < 4'd12))
      result_mem[wr_idx] <= wr_data; // [R6]
  end

  assign rd_data = (rd_idx < 4'd12) ? result_mem[rd_idx] : 12'h000;

endmodule // result_store

`default_nettype wire

// [adc_sw_checker_asserts.sv]
// Port checker of the software-started conversion unit
`default_nettype none
`include "adc_sw_map.vh"
module adc_sw_checker
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Converter and interrupt
  input wire logic [4:0]  conv_channel,
  input wire logic        conv_start,
  input wire logic        software_conversion_done_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // Bus answer timing
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_ready_wait: assert property (psel && $rose(penable) |-> ##1 pready) else $error("late pready");
  a_ready_access: assert property (pready |-> psel && penable) else $error("stray pready");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
  ////////////////////////////////////////
  // Converter side and interrupt
  a_start_pulse: assert property (conv_start |=> !conv_start) else $error("start held");
  a_channel_hold: assert property ($changed(conv_channel) |-> conv_start) else $error("channel moved");
  a_start_code: assert property (conv_start |-> conv_channel inside {`CH_NINE, `CH_TEN, `CH_ELEVEN,
    `CH_TWELVE, `CH_SIXTEEN}) else $error("reserved channel");
  a_irq_clear: assert property ($fell(software_conversion_done_irq) |-> $past(pready, 2))
    else $error("irq dropped");
  // Main scenarios
  cover property (pslverr);
  cover property (conv_start && conv_channel == `CH_SIXTEEN);
  cover property ($rose(software_conversion_done_irq));
endmodule // adc_sw_checker

bind adc_sw_trigger adc_sw_checker chk (.ref_clk, .rst_b, .psel, .penable, .prdata, .pready, .pslverr,
  .conv_channel, .conv_start, .software_conversion_done_irq);
`default_nettype wire

// [adc_sw_trigger_test.sv]
// Self-checking bench of the software-started conversion unit
`default_nettype none
`include "adc_sw_map.vh"
module adc_sw_trigger_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic x;} row_t;
  logic        ref_clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, conv_start, irq, err;
  logic [4:0]  conv_channel;
  logic        conv_done = 1'h0, mute = 1'h0;
  logic [11:0] conv_data = 12'h0;
  logic [3:0]  seq = 4'h0;
  int          failures = 0;
  int          checked = 0;
  row_t        rows[4] = '{'{`SLOTS_0_3_OFS, 32'hffffffff, 32'h9f9f9f9f, 1'h0},
    '{`SLOTS_4_7_OFS, 32'h12345678, 32'h12141618, 1'h0},
    '{`SLOTS_8_11_OFS, 32'he0606090, 32'h80000090, 1'h0}, '{12'h01c, 32'hffffffff, 32'h0, 1'h1}};
  logic [31:0] exp_res[12] = '{32'h209, 32'h0, 32'h230, 32'h0, 32'h0, 32'h24b, 32'h0, 32'h26c,
    32'h0, 32'h0, 32'h0, 32'h28a};

  adc_sw_trigger DUT
  (
    .ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .conv_channel, .conv_start, .conv_done, .conv_data, .software_conversion_done_irq(irq)
  );

  ////////////////////////////////////////
  // Clock, watchdog and tasks
  initial forever #10 ref_clk = ~ref_clk;

  initial
  begin
    #200us;
    failures++;
    report_and_stop;
  end

  task automatic report_and_stop;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One bus transfer, held until pready is seen
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    // Values read just after an edge are the ones that edge sampled
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Converter stand-in: result carries order and channel
  initial forever
  begin
    @(negedge ref_clk);
    if (conv_start === 1'h1 && mute !== 1'h1)
    begin
      repeat (3) @(posedge ref_clk);
      conv_data <= {3'h1, seq, conv_channel};
      @(posedge ref_clk);
      conv_done <= 1'h1;
      repeat (4) @(posedge ref_clk);
      conv_done <= 1'h0;
      conv_data <= ~conv_data;
      seq <= seq + 4'h1;
    end
  end

  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'h1;
    foreach (rows[i])
    begin
      xfer(1'h1, rows[i].a, rows[i].d);
      xfer(1'h0, rows[i].a, 32'h0);
      check("read", rd, rows[i].e);
      check("slverr", {31'h0, err}, {31'h0, rows[i].x});
    end
    // Reset in mid-run clears the slots
    rst_b <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'h1;
    for (int r = 0; r < 3; r++)
    begin
      xfer(1'h0, 12'(4 * r), 32'h0);
      check("reset", rd, 32'h0);
    end
    // Mixed slots, a reserved code and a start while busy
    xfer(1'h1, `SLOTS_0_3_OFS, 32'h81900a89);
    xfer(1'h1, `SLOTS_4_7_OFS, 32'h8c008b00);
    xfer(1'h1, `SLOTS_8_11_OFS, 32'h8a000000);
    xfer(1'h1, `IRQ_MASK_OFS, 32'h1);
    xfer(1'h1, `START_OFS, 32'h1);
    xfer(1'h1, `START_OFS, 32'h1);
    for (int n = 0; n < 3000 && irq !== 1'h1; n++)
      @(negedge ref_clk);
    check("irq", {31'h0, irq}, 32'h1);
    for (int s = 0; s < 12; s++)
    begin
      xfer(1'h0, 12'(`RESULT_BASE_OFS + 4 * s), 32'h0);
      check("result", rd, exp_res[s]);
    end
    xfer(1'h0, `IRQ_STATUS_OFS, 32'h0);
    check("status", rd, 32'h3);
    repeat (3) @(negedge ref_clk);
    check("irq off", {31'h0, irq}, 32'h0);
    // Masked run with every slot disabled
    xfer(1'h1, `IRQ_MASK_OFS, 32'h0);
    for (int r = 0; r < 3; r++)
      xfer(1'h1, 12'(4 * r), 32'h0);
    xfer(1'h1, `START_OFS, 32'h1);
    repeat (10) @(negedge ref_clk);
    check("masked", {31'h0, irq}, 32'h0);
    xfer(1'h0, `IRQ_STATUS_OFS, 32'h0);
    check("empty run", rd, 32'h1);
    // Silent converter: slot times out, its result is kept, the run still ends
    mute <= 1'h1;
    xfer(1'h1, `SLOTS_0_3_OFS, 32'h00000089);
    xfer(1'h1, `START_OFS, 32'h1);
    repeat (20) @(negedge ref_clk);
    xfer(1'h0, `STATUS_OFS, 32'h0);
    check("busy", rd, 32'h10);
    repeat (250) @(negedge ref_clk);
    xfer(1'h0, `IRQ_STATUS_OFS, 32'h0);
    check("timeout", rd, 32'h1);
    xfer(1'h0, `RESULT_BASE_OFS, 32'h0);
    check("kept", rd, 32'h209);
    report_and_stop;
  end
endmodule // adc_sw_trigger_test
`default_nettype wire
